/* xab_bank_checker.sv */
// concurrent checks on the ports of the extended addressing register bank
`include "xab_defs.svh"
module xab_bank_checker
(
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire xab_pkg::xab_sfr_req_s sfrReq,
  input wire logic [7:0]            sfrRdData,
  input wire xab_pkg::xab_bus_req_s busReq,
  input wire xab_pkg::xab_pwr_e     pwrMode,
  input wire logic [7:0]            auxPortOutput,
  input wire logic [7:0]            middleAddressPins,
  input wire logic [7:0]            highAddressPins,
  input wire logic [3:0]            bankAddressPins,
  input wire logic                  addrLatchStrobe,
  input wire logic                  programStoreStrobe_n,
  input wire logic                  extDataBusOe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic runMode = pwrMode == xab_pkg::PWR_RUN;
  wire logic xri     = busReq.cyc == xab_pkg::CYC_XRI && runMode;
  wire logic pgWr    = sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == `XAB_OFS_PAGE_HI;
  wire logic oneLow  = bankAddressPins == 4'h0 || $onehot(~bankAddressPins);
  property p_page;
    pgWr ##1 xri |=> highAddressPins == $past(sfrReq.wdata, 2);
  endproperty
  a_page: assert property (p_page) else $error("page byte missing");
  property p_ptr;
    xri |=> middleAddressPins == $past(busReq.riPtr);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer byte missing");
  property p_idle;
    pwrMode == xab_pkg::PWR_IDLE |=> addrLatchStrobe && programStoreStrobe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("idle strobes wrong");
  property p_down;
    pwrMode == xab_pkg::PWR_DOWN |=> !addrLatchStrobe && !programStoreStrobe_n;
  endproperty
  a_down: assert property (p_down) else $error("down strobes wrong");
  property p_float;
    !runMode |=> !extDataBusOe;
  endproperty
  a_float: assert property (p_float) else $error("bus driven in low power");
  property p_hold;
    !runMode |=> $stable(highAddressPins) && $stable(middleAddressPins);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved in low power");
  property p_lpbank;
    !runMode [*2] |=> oneLow;
  endproperty
  a_lpbank: assert property (p_lpbank) else $error("bank pins wrong in low power");
  property p_rsv;
    sfrReq.rd && sfrReq.addr == `XAB_OFS_BANK_CTL |=> sfrRdData[6:4] == `XAB_BANK_RSV_VAL;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
  // the output pins lag the latch by one cycle, as does the read data
  property p_aux;
    sfrReq.rd && sfrReq.rmw && sfrReq.addr == `XAB_OFS_AUX_PORT |=> sfrRdData == auxPortOutput;
  endproperty
  a_aux: assert property (p_aux) else $error("aux latch read wrong");
  c_xri: cover property (xri);
  c_page: cover property (pgWr ##1 xri);
  c_down: cover property (pwrMode == xab_pkg::PWR_DOWN);
  c_rmw: cover property (sfrReq.rd && sfrReq.rmw);
endmodule

/* xab_defs.svh */
// offsets, reset values, field positions and codes of the extended addressing register bank
`ifndef XAB_DEFS_SVH
`define XAB_DEFS_SVH
`define XAB_OFS_PAGE_HI   8'hA1
`define XAB_OFS_BANK_CTL  8'hA2
`define XAB_OFS_AUX_PORT  8'hA6
`define XAB_OFS_IRQ_CTL   8'hC0
`define XAB_RST_PAGE_HI   8'h00
`define XAB_RST_BANK_CTL  8'h70
`define XAB_RST_AUX_PORT  8'hFF
`define XAB_RST_IRQ_CTL   8'h00
`define XAB_BANK_MODE_BIT 7
`define XAB_BANK_RSV_VAL  3'h7
`define XAB_IRQ_C_TRIG    0
`define XAB_IRQ_C_FLAG    1
`define XAB_IRQ_D_TRIG    4
`define XAB_IRQ_D_FLAG    5
`define XAB_IRQ_C_EN      2
`define XAB_IRQ_D_EN      6
`define XAB_BITADR_BASE   5'h18
`endif

/* xab_pin_model.sv */
// pin-side model: aux port wiring and the two extra interrupt lines
module xab_pin_model
(
  input wire logic [7:0] auxPortOutput,
  input wire logic       irqPullC,
  input wire logic       irqPullD,
  output logic [7:0]     auxPortIn,
  output logic           extraIrqCInput_n,
  output logic           extraIrqDInput_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // quasi-bidirectional port reads back its latch; lines sit high unless pulled
  assign auxPortIn = auxPortOutput;
  assign extraIrqCInput_n = !irqPullC;
  assign extraIrqDInput_n = !irqPullD;
endmodule

/* xab_pkg.sv */
// types shared by the extended addressing register bank
package xab_pkg;
  typedef enum logic [2:0]
  {
    CYC_NONE  = 3'h0,
    CYC_FETCH = 3'h1,
    CYC_TABLE = 3'h2,
    CYC_XDPTR = 3'h3,
    CYC_XRI   = 3'h4
  } xab_cyc_e;
  typedef enum logic [1:0]
  {
    PWR_RUN  = 2'h0,
    PWR_IDLE = 2'h1,
    PWR_DOWN = 2'h2
  } xab_pwr_e;
  typedef struct packed
  {
    logic       rd;
    logic       rmw;
    logic       wr;
    logic       bitOp;
    logic       bitVal;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xab_sfr_req_s;
  typedef struct packed
  {
    xab_cyc_e    cyc;
    logic [15:0] addr;
    logic [7:0]  riPtr;
    logic        ale;
    logic        program_store_strobe;
    logic [7:0]  dout;
    logic        doe;
  } xab_bus_req_s;
endpackage

/* xab_sfr_bank.sv */
// extended addressing special function register bank with its pin drivers
//
// Summary of operation
// - indirect external move through 8-bit pointer drives page byte on high address pins.
// - page byte register is 8-bit read/write and resets to zero.
// - page byte register ignores single-bit set and clear operations.
// - bank control bit 7 selects pin function; bits 3-0 give pin values when zero.
// - bank control register bits 7 and 3-0 are read/write, reset value hex 70.
// - aux port register drives aux port pins, resets to all ones.
// - extra interrupt control register holds config and status, resets zero, bit-addressable.
// - only the extra interrupt control register accepts bit-level access.
// - all four registers take direct and read-modify-write reads and writes.
// - idle holds both strobes high, power-down low; ports keep data, bus floats.
// - in low power, bank pins show zero or decoded chip select per mode bit.
// - chip-select mode drives exactly one bank pin low per 16K region.
// - bank control bits 6-4 always read back as 111.
// - bank mode drives low nibble only on table reads and data moves, else zero.
`include "xab_defs.svh"
module xab_sfr_bank
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire xab_pkg::xab_sfr_req_s sfrReq,
  output logic [7:0]                 sfrRdData,
  input  wire xab_pkg::xab_bus_req_s busReq,
  input  wire xab_pkg::xab_pwr_e     pwrMode,
  input  wire logic                  irqAckC,
  input  wire logic                  irqAckD,
  input  wire logic                  extraIrqCInput_n,
  input  wire logic                  extraIrqDInput_n,
  output logic                       irqReqC,
  output logic                       irqReqD,
  input  wire logic [7:0]            auxPortIn,
  output logic [7:0]                 auxPortOutput,
  output logic [7:0]                 middleAddressPins,
  output logic [7:0]                 highAddressPins,
  output logic [3:0]                 bankAddressPins,
  output logic                       addrLatchStrobe,
  output logic                       programStoreStrobe_n,
  output logic [7:0]                 extDataBusOut,
  output logic                       extDataBusOe
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] pageHighByte_r;
  logic [7:0] bankSelCtl_r;
  logic [7:0] auxPort_r;
  logic [7:0] irqCtl_r;
  logic [7:0] irqCtl_nxt;
  logic [1:0] irqMeta_r;
  logic [1:0] irqSync_r;
  logic [1:0] irqPrev_r;
  logic [7:0] auxMeta_r;
  logic [7:0] auxSync_r;
  logic [7:0] rdData_nxt;
  logic [15:0] busAddr;
  logic [3:0] bankNibble;
  logic [3:0] chipSel;
  logic       lowPower;
  logic       extCycle;
  logic       wrPage;
  logic       wrBank;
  logic       wrAux;
  logic       wrIrq;
  logic       bitIrq;
  logic [2:0] bitIdx;
  logic [1:0] fallEdge;
  logic [1:0] irqAck;
  ////////////////////////////////////////////////////////////////////////////
  // whole-register writes decode on full byte address; bit ops only hit the
  // interrupt control register
  assign wrPage = sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == `XAB_OFS_PAGE_HI;
  assign wrBank = sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == `XAB_OFS_BANK_CTL;
  assign wrAux  = sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == `XAB_OFS_AUX_PORT;
  assign wrIrq  = sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == `XAB_OFS_IRQ_CTL;
  assign bitIrq = sfrReq.wr && sfrReq.bitOp
                  && sfrReq.addr[7:3] == `XAB_BITADR_BASE;
  assign bitIdx = sfrReq.addr[2:0];
  assign lowPower = pwrMode != xab_pkg::PWR_RUN;
  ////////////////////////////////////////////////////////////////////////////
  // external address formation
  assign busAddr = (busReq.cyc == xab_pkg::CYC_XRI)
                   ? {pageHighByte_r, busReq.riPtr}
                   : busReq.addr;
  assign extCycle = busReq.cyc == xab_pkg::CYC_TABLE
                    || busReq.cyc == xab_pkg::CYC_XDPTR
                    || busReq.cyc == xab_pkg::CYC_XRI;
  // one-hot-low select from the top two bits of the high address pins
  assign chipSel = ~(4'h1 << highAddressPins[7:6]);
  assign bankNibble = bankSelCtl_r[`XAB_BANK_MODE_BIT] ? chipSel
                    : (extCycle && !lowPower) ? bankSelCtl_r[3:0]
                    : 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // interrupt input conditioning
  assign fallEdge = irqPrev_r & ~irqSync_r;
  assign irqAck = {irqAckD, irqAckC};
  always_comb
  begin
    irqCtl_nxt = irqCtl_r;
    if (wrIrq)
    begin
      irqCtl_nxt = sfrReq.wdata;
    end
    if (bitIrq)
    begin
      irqCtl_nxt[bitIdx] = sfrReq.bitVal;
    end
    // edge flags: acknowledge clears, a new edge in the same cycle wins
    if (irqCtl_r[`XAB_IRQ_C_TRIG])
    begin
      if (irqAck[0])
      begin
        irqCtl_nxt[`XAB_IRQ_C_FLAG] = 1'b0;
      end
      if (fallEdge[0])
      begin
        irqCtl_nxt[`XAB_IRQ_C_FLAG] = 1'b1;
      end
    end
    else
    begin
      irqCtl_nxt[`XAB_IRQ_C_FLAG] = ~irqSync_r[0];
    end
    if (irqCtl_r[`XAB_IRQ_D_TRIG])
    begin
      if (irqAck[1])
      begin
        irqCtl_nxt[`XAB_IRQ_D_FLAG] = 1'b0;
      end
      if (fallEdge[1])
      begin
        irqCtl_nxt[`XAB_IRQ_D_FLAG] = 1'b1;
      end
    end
    else
    begin
      irqCtl_nxt[`XAB_IRQ_D_FLAG] = ~irqSync_r[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // read mux: port reads see the pins, read-modify-write sees the latch
  always_comb
  begin
    case (sfrReq.addr)
      `XAB_OFS_PAGE_HI:  rdData_nxt = pageHighByte_r;
      `XAB_OFS_BANK_CTL: rdData_nxt = {bankSelCtl_r[7], `XAB_BANK_RSV_VAL,
                                       bankSelCtl_r[3:0]};
      `XAB_OFS_AUX_PORT: rdData_nxt = sfrReq.rmw ? auxPort_r : auxSync_r;
      `XAB_OFS_IRQ_CTL:  rdData_nxt = irqCtl_r;
      default:           rdData_nxt = 8'h00;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    irqMeta_r <= {extraIrqDInput_n, extraIrqCInput_n};
    irqSync_r <= irqMeta_r;
    auxMeta_r <= auxPortIn;
    auxSync_r <= auxMeta_r;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pageHighByte_r <= `XAB_RST_PAGE_HI;
      bankSelCtl_r   <= `XAB_RST_BANK_CTL;
      auxPort_r      <= `XAB_RST_AUX_PORT;
      irqCtl_r       <= `XAB_RST_IRQ_CTL;
      irqPrev_r      <= 2'h3;
      sfrRdData      <= 8'h00;
    end
    else
    begin
      if (wrPage)
      begin
        pageHighByte_r <= sfrReq.wdata;
      end
      if (wrBank)
      begin
        bankSelCtl_r <= sfrReq.wdata;
      end
      if (wrAux)
      begin
        auxPort_r <= sfrReq.wdata;
      end
      irqCtl_r  <= irqCtl_nxt;
      irqPrev_r <= irqSync_r;
      if (sfrReq.rd)
      begin
        sfrRdData <= rdData_nxt;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; in idle and power-down the middle and high address pins hold
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      middleAddressPins    <= 8'h00;
      highAddressPins      <= 8'h00;
      bankAddressPins      <= 4'h0;
      addrLatchStrobe      <= 1'b1;
      programStoreStrobe_n <= 1'b1;
      extDataBusOut        <= 8'h00;
      extDataBusOe         <= 1'b0;
      auxPortOutput        <= `XAB_RST_AUX_PORT;
      irqReqC              <= 1'b0;
      irqReqD              <= 1'b0;
    end
    else
    begin
      auxPortOutput   <= auxPort_r;
      bankAddressPins <= bankNibble;
      irqReqC <= irqCtl_r[`XAB_IRQ_C_FLAG] && irqCtl_r[`XAB_IRQ_C_EN];
      irqReqD <= irqCtl_r[`XAB_IRQ_D_FLAG] && irqCtl_r[`XAB_IRQ_D_EN];
      if (lowPower)
      begin
        addrLatchStrobe      <= pwrMode == xab_pkg::PWR_IDLE;
        programStoreStrobe_n <= pwrMode == xab_pkg::PWR_IDLE;
        extDataBusOe         <= 1'b0;
      end
      else
      begin
        addrLatchStrobe      <= busReq.ale;
        programStoreStrobe_n <= busReq.program_store_strobe;
        extDataBusOe         <= busReq.doe;
        extDataBusOut        <= busReq.dout;
        if (busReq.cyc != xab_pkg::CYC_NONE)
        begin
          middleAddressPins <= busAddr[7:0];
          highAddressPins   <= busAddr[15:8];
        end
      end
    end
  end
endmodule

/* xab_sfr_bank_tb_top.sv */
// self-checking bench for the extended addressing register bank
module xab_sfr_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, irqAckC, irqPullC, irqReqC, addrLatchStrobe, programStoreStrobe_n;
  logic extDataBusOe, extraIrqCInput_n, extraIrqDInput_n;
  logic irqAckD, irqPullD, irqReqD;
  logic [7:0] sfrRdData, auxPortIn, auxPortOutput, middleAddressPins, highAddressPins;
  logic [7:0] extDataBusOut;
  logic [3:0] bankAddressPins;
  xab_pkg::xab_sfr_req_s sfrReq;
  xab_pkg::xab_bus_req_s busReq;
  xab_pkg::xab_pwr_e     pwrMode;
  int err_count = 0;
  int compares = 0;
  xab_sfr_bank dut (.mclk, .rst_n, .sfrReq, .sfrRdData, .busReq, .pwrMode, .irqAckC,
    .irqAckD, .extraIrqCInput_n, .extraIrqDInput_n, .irqReqC, .irqReqD, .auxPortIn,
    .auxPortOutput, .middleAddressPins, .highAddressPins, .bankAddressPins, .addrLatchStrobe,
    .programStoreStrobe_n, .extDataBusOut, .extDataBusOe);
  xab_pin_model pm (.auxPortOutput, .irqPullC, .irqPullD, .auxPortIn,
    .extraIrqCInput_n, .extraIrqDInput_n);
  initial
  begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  task sfr(input logic w, m, b, v, input logic [7:0] a, d);
    @(negedge mclk);
    sfrReq = '{rd: !w, rmw: m, wr: w, bitOp: b, bitVal: v, addr: a, wdata: d};
    @(negedge mclk);
    sfrReq = '0;
  endtask
  task rdc(input logic m, input logic [7:0] a, input logic [7:0] exp);
    sfr(1'b0, m, 1'b0, 1'b0, a, 8'h00);
    @(negedge mclk);
    chk(sfrRdData, exp);
  endtask
  task bus(input xab_pkg::xab_cyc_e c, input logic [15:0] a, input logic [7:0] r);
    @(negedge mclk);
    busReq.cyc = c;
    busReq.addr = a;
    busReq.riPtr = r;
    repeat (2) @(negedge mclk);
  endtask
  task summarize();
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    rst_n = 0;
    sfrReq = '0;
    busReq = '{cyc: xab_pkg::CYC_NONE, addr: 0, riPtr: 0, ale: 0, program_store_strobe: 1, dout: 8'hA5, doe: 1};
    pwrMode = xab_pkg::PWR_RUN;
    irqAckC = 0;
    irqPullC = 0;
    irqAckD = 0;
    irqPullD = 0;
    repeat (16) @(negedge mclk);
    rst_n = 1;
    rdc(0, 8'hA1, 8'h00);
    rdc(0, 8'hA2, 8'h70);
    rdc(1, 8'hA6, 8'hFF);
    rdc(0, 8'hC0, 8'h00);
    sfr(1, 0, 0, 0, 8'hA1, 8'h5A);
    sfr(1, 0, 0, 0, 8'hA2, 8'h0F);
    sfr(1, 0, 0, 0, 8'hA6, 8'h3C);
    // bit sets aimed at the byte-only registers must be dropped
    for (int i = 0; i < 8; i++)
      sfr(1, 0, 1, 1, 8'(8'hA0 + i), 8'h00);
    rdc(0, 8'hA1, 8'h5A);
    rdc(0, 8'hA2, 8'h7F);
    rdc(1, 8'hA6, 8'h3C);
    rdc(0, 8'hA6, 8'h3C);
    chk(auxPortOutput, 8'h3C);
    sfr(1, 0, 1, 1, 8'hC0, 8'h00);
    sfr(1, 0, 1, 1, 8'hC2, 8'h00);
    rdc(0, 8'hC0, 8'h05);
    irqPullC = 1;
    repeat (6) @(negedge mclk);
    chk(irqReqC, 1'b1);
    irqAckC = 1;
    @(negedge mclk);
    irqAckC = 0;
    repeat (2) @(negedge mclk);
    chk(irqReqC, 1'b0);
    // second line in level mode: flag follows the pin, service pulse has no effect
    sfr(1, 0, 1, 1, 8'hC6, 8'h00);
    irqPullD = 1;
    repeat (6) @(negedge mclk);
    chk(irqReqD, 1'b1);
    irqAckD = 1;
    @(negedge mclk);
    irqAckD = 0;
    repeat (2) @(negedge mclk);
    chk(irqReqD, 1'b1);
    rdc(0, 8'hC0, 8'h65);
    irqPullD = 0;
    repeat (6) @(negedge mclk);
    chk(irqReqD, 1'b0);
    // page write directly followed by the pointer move
    @(negedge mclk);
    sfrReq.wr = 1'b1;
    sfrReq.addr = 8'hA1;
    sfrReq.wdata = 8'hFF;
    @(negedge mclk);
    sfrReq = '0;
    busReq.cyc = xab_pkg::CYC_XRI;
    busReq.riPtr = 8'h00;
    repeat (2) @(negedge mclk);
    chk({highAddressPins, middleAddressPins}, 16'hFF00);
    sfr(1, 0, 0, 0, 8'hA1, 8'h12);
    bus(xab_pkg::CYC_XRI, 16'h0000, 8'h34);
    chk({highAddressPins, middleAddressPins}, 16'h1234);
    chk(bankAddressPins, 4'hF);
    chk({extDataBusOe, extDataBusOut}, 16'h01A5);
    bus(xab_pkg::CYC_FETCH, 16'h0100, 8'h00);
    chk(bankAddressPins, 4'h0);
    sfr(1, 0, 0, 0, 8'hA2, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      bus(xab_pkg::CYC_XDPTR, 16'(i) << 14, 8'h00);
      chk(bankAddressPins ^ 4'(1 << i), 4'hF);
    end
    pwrMode = xab_pkg::PWR_IDLE;
    busReq.addr = 16'h0000;
    repeat (2) @(negedge mclk);
    chk({addrLatchStrobe, programStoreStrobe_n, extDataBusOe}, 3'b110);
    chk({highAddressPins, bankAddressPins}, 12'hC07);
    pwrMode = xab_pkg::PWR_DOWN;
    repeat (2) @(negedge mclk);
    chk({addrLatchStrobe, programStoreStrobe_n, extDataBusOe}, 3'b000);
    // back to bank mode while powered down: bank pins drop to zero, address holds
    sfr(1, 0, 0, 0, 8'hA2, 8'h05);
    repeat (2) @(negedge mclk);
    chk({highAddressPins, bankAddressPins}, 12'hC00);
    summarize();
  end
  initial
  begin
    #20000;
    err_count++;
    summarize();
  end
endmodule
bind xab_sfr_bank xab_bank_checker chk (.mclk, .rst_n, .sfrReq, .sfrRdData, .busReq,
  .pwrMode, .auxPortOutput, .middleAddressPins, .highAddressPins, .bankAddressPins,
  .addrLatchStrobe, .programStoreStrobe_n, .extDataBusOe);
